// ===== core/poe_defs.svh
`ifndef POE_DEFS_SVH
`define POE_DEFS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define POE_IDX_W        14
`define POE_IDX_A_DATA   14'h0000
`define POE_IDX_B_DATA   14'h0001
`define POE_IDX_A_OE     14'h30b0
`define POE_IDX_B_OE     14'h30b1
`define POE_ADDR_W       16
`define POE_ADDR_LSB     2

// ----------------------------------------------------------------
// pin group widths and reset values
// ----------------------------------------------------------------
`define POE_A_W          6
`define POE_B_W          8
`define POE_REG_W        8
`define POE_REG_RST      8'h00
`define POE_DATA_W       32

// ----------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------
`define POE_RESP_OKAY    2'h0
`define POE_RESP_SLVERR  2'h2

`endif

// ===== core/poe_pin_sync.sv
`include "poe_defs.svh"

// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module poe_pin_sync
    import poe_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    // take a new level only where stages two and three agree
    always_comb begin
        level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);
    end

    // stage one feeds stage two alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else if (clk_en) begin
            s1_q    <= pin_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule

// ===== core/poe_pkg.sv
// ----------------------------------------------------------------
// shared types of the output-enable block
// ----------------------------------------------------------------
package poe_pkg;

    // write channel progress
    typedef enum logic [0:0] {
        POE_WR_IDLE,
        POE_WR_RESP
    } poe_wr_state_e;

    // read channel progress
    typedef enum logic [0:0] {
        POE_RD_IDLE,
        POE_RD_RESP
    } poe_rd_state_e;

    typedef logic [1:0] poe_resp_t;

endpackage

// ===== core/poe_port_slice.sv
`include "poe_defs.svh"

// ----------------------------------------------------------------
// data latch and drive enable of one pin group
// ----------------------------------------------------------------
module poe_port_slice
    import poe_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  clk_en,
    input  wire logic                  data_we,
    input  wire logic                  oe_we,
    input  wire logic [`POE_REG_W-1:0] wr_byte,
    input  wire logic [W-1:0]          pin_level,
    output logic      [`POE_REG_W-1:0] data_rd,
    output logic      [`POE_REG_W-1:0] oe_rd,
    output logic      [W-1:0]          pin_o,
    output logic      [W-1:0]          pin_oe
);

    logic [W-1:0] data_q;
    logic [W-1:0] data_d;
    logic [W-1:0] oe_q;
    logic [W-1:0] oe_d;

    // bits above the group width are never stored
    always_comb begin
        data_d = data_we ? wr_byte[W-1:0] : data_q;
        oe_d   = oe_we ? wr_byte[W-1:0] : oe_q;
    end

    // reset leaves every pin undriven
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= W'(`POE_REG_RST);
            oe_q   <= W'(`POE_REG_RST);
        end else if (clk_en) begin
            data_q <= data_d;
            oe_q   <= oe_d;
        end
    end

    // readback, unused upper bits read zero
    always_comb begin
        data_rd = `POE_REG_RST;
        oe_rd   = `POE_REG_RST;
        for (int i = 0; i < W; i++) begin
            data_rd[i] = oe_q[i] ? data_q[i] : pin_level[i];
            oe_rd[i]   = oe_q[i];
        end
    end

    // pins drive the latched level while enabled
    assign pin_o  = data_q;
    assign pin_oe = oe_q;

endmodule

// ===== core/poe_top.sv
`include "poe_defs.svh"

// ----------------------------------------------------------------
// output-enable control for pin groups a and b, axi4-lite slave
// ----------------------------------------------------------------
module poe_top
    import poe_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    clk_en,
    // write address channel
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [`POE_ADDR_W-1:0]  awaddr,
    // write data channel
    input  wire logic                    wvalid,
    output logic                         wready,
    input  wire logic [`POE_DATA_W-1:0]  wdata,
    input  wire logic [3:0]              wstrb,
    // write response channel
    output logic                         bvalid,
    input  wire logic                    bready,
    output logic      [1:0]              bresp,
    // read address channel
    input  wire logic                    arvalid,
    output logic                         arready,
    input  wire logic [`POE_ADDR_W-1:0]  araddr,
    // read data channel
    output logic                         rvalid,
    input  wire logic                    rready,
    output logic      [`POE_DATA_W-1:0]  rdata,
    output logic      [1:0]              rresp,
    // group a pins
    input  wire logic [`POE_A_W-1:0]     group_a_pin_i,
    output logic      [`POE_A_W-1:0]     group_a_pin_o,
    output logic      [`POE_A_W-1:0]     group_a_pin_oe,
    // group b pins
    input  wire logic [`POE_B_W-1:0]     group_b_pin_i,
    output logic      [`POE_B_W-1:0]     group_b_pin_o,
    output logic      [`POE_B_W-1:0]     group_b_pin_oe
);

    // ------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------
    poe_wr_state_e              wr_st_q;
    poe_wr_state_e              wr_st_d;
    logic                       aw_have_q;
    logic                       aw_have_d;
    logic [`POE_IDX_W-1:0]      aw_idx_q;
    logic [`POE_IDX_W-1:0]      aw_idx_d;
    logic                       w_have_q;
    logic                       w_have_d;
    logic [`POE_REG_W-1:0]      wbyte_q;
    logic [`POE_REG_W-1:0]      wbyte_d;
    logic                       wlane_q;
    logic                       wlane_d;
    poe_resp_t                  bresp_q;
    poe_resp_t                  bresp_d;
    logic                       aw_hs;
    logic                       w_hs;
    logic                       wr_go;
    logic                       wr_hit;

    // ------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------
    logic                       a_data_we;
    logic                       a_oe_we;
    logic                       b_data_we;
    logic                       b_oe_we;

    // ------------------------------------------------------------
    // read channel state
    // ------------------------------------------------------------
    poe_rd_state_e              rd_st_q;
    poe_rd_state_e              rd_st_d;
    logic [`POE_DATA_W-1:0]     rdata_q;
    logic [`POE_DATA_W-1:0]     rdata_d;
    poe_resp_t                  rresp_q;
    poe_resp_t                  rresp_d;
    logic                       ar_hs;
    logic [`POE_IDX_W-1:0]      ar_idx;

    // ------------------------------------------------------------
    // group readback and synchronised pin levels
    // ------------------------------------------------------------
    logic [`POE_A_W-1:0]        a_level;
    logic [`POE_B_W-1:0]        b_level;
    logic [`POE_REG_W-1:0]      a_data_rd;
    logic [`POE_REG_W-1:0]      a_oe_rd;
    logic [`POE_REG_W-1:0]      b_data_rd;
    logic [`POE_REG_W-1:0]      b_oe_rd;

    // ------------------------------------------------------------
    // write address and data acceptance
    // ------------------------------------------------------------

    // each channel is taken once, only while no response waits
    assign awready = clk_en && !aw_have_q && (wr_st_q == POE_WR_IDLE);
    assign wready  = clk_en && !w_have_q && (wr_st_q == POE_WR_IDLE);
    assign aw_hs   = awvalid && awready;
    assign w_hs    = wvalid && wready;

    // the write happens once both halves are held
    assign wr_go = (wr_st_q == POE_WR_IDLE) && aw_have_q && w_have_q;

    // address hit check for the held write
    always_comb begin
        if (aw_idx_q == `POE_IDX_A_DATA) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `POE_IDX_B_DATA) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `POE_IDX_A_OE) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `POE_IDX_B_OE) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // write strobe decode, low byte lane must be enabled
    always_comb begin
        a_data_we = 1'b0;
        a_oe_we   = 1'b0;
        b_data_we = 1'b0;
        b_oe_we   = 1'b0;
        if (wr_go && wlane_q) begin
            if (aw_idx_q == `POE_IDX_A_DATA) begin
                a_data_we = 1'b1;
            end else if (aw_idx_q == `POE_IDX_B_DATA) begin
                b_data_we = 1'b1;
            end else if (aw_idx_q == `POE_IDX_A_OE) begin
                a_oe_we = 1'b1;
            end else if (aw_idx_q == `POE_IDX_B_OE) begin
                b_oe_we = 1'b1;
            end
        end
    end

    // write channel next state
    always_comb begin
        wr_st_d   = wr_st_q;
        aw_have_d = aw_have_q;
        aw_idx_d  = aw_idx_q;
        w_have_d  = w_have_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bresp_d   = bresp_q;
        if (aw_hs) begin
            aw_have_d = 1'b1;
            aw_idx_d  = awaddr[`POE_ADDR_W-1:`POE_ADDR_LSB];
        end
        if (w_hs) begin
            w_have_d = 1'b1;
            wbyte_d  = wdata[`POE_REG_W-1:0];
            wlane_d  = wstrb[0];
        end
        case (wr_st_q)
            POE_WR_IDLE: begin
                if (wr_go) begin
                    wr_st_d   = POE_WR_RESP;
                    aw_have_d = 1'b0;
                    w_have_d  = 1'b0;
                    bresp_d   = wr_hit ? `POE_RESP_OKAY : `POE_RESP_SLVERR;
                end
            end
            POE_WR_RESP: begin
                if (bready) begin
                    wr_st_d = POE_WR_IDLE;
                end
            end
            default: begin
                wr_st_d = POE_WR_IDLE;
            end
        endcase
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_q   <= POE_WR_IDLE;
            aw_have_q <= 1'b0;
            aw_idx_q  <= '0;
            w_have_q  <= 1'b0;
            wbyte_q   <= `POE_REG_RST;
            wlane_q   <= 1'b0;
            bresp_q   <= `POE_RESP_OKAY;
        end else if (clk_en) begin
            wr_st_q   <= wr_st_d;
            aw_have_q <= aw_have_d;
            aw_idx_q  <= aw_idx_d;
            w_have_q  <= w_have_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
            bresp_q   <= bresp_d;
        end
    end

    assign bvalid = (wr_st_q == POE_WR_RESP);
    assign bresp  = bresp_q;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------

    // one read at a time, address taken while idle
    assign arready = clk_en && (rd_st_q == POE_RD_IDLE);
    assign ar_hs   = arvalid && arready;
    assign ar_idx  = araddr[`POE_ADDR_W-1:`POE_ADDR_LSB];

    // read decode and response next state
    always_comb begin
        rd_st_d = rd_st_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rd_st_q)
            POE_RD_IDLE: begin
                if (ar_hs) begin
                    rd_st_d = POE_RD_RESP;
                    rresp_d = `POE_RESP_OKAY;
                    rdata_d = '0;
                    if (ar_idx == `POE_IDX_A_DATA) begin
                        rdata_d[`POE_REG_W-1:0] = a_data_rd;
                    end else if (ar_idx == `POE_IDX_B_DATA) begin
                        rdata_d[`POE_REG_W-1:0] = b_data_rd;
                    end else if (ar_idx == `POE_IDX_A_OE) begin
                        rdata_d[`POE_REG_W-1:0] = a_oe_rd;
                    end else if (ar_idx == `POE_IDX_B_OE) begin
                        rdata_d[`POE_REG_W-1:0] = b_oe_rd;
                    end else begin
                        rresp_d = `POE_RESP_SLVERR;
                    end
                end
            end
            POE_RD_RESP: begin
                if (rready) begin
                    rd_st_d = POE_RD_IDLE;
                end
            end
            default: begin
                rd_st_d = POE_RD_IDLE;
            end
        endcase
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_q <= POE_RD_IDLE;
            rdata_q <= '0;
            rresp_q <= `POE_RESP_OKAY;
        end else if (clk_en) begin
            rd_st_q <= rd_st_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign rvalid = (rd_st_q == POE_RD_RESP);
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    poe_pin_sync #(
        .W       (`POE_A_W)
    ) u_sync_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .pin_i   (group_a_pin_i),
        .level   (a_level)
    );

    poe_pin_sync #(
        .W       (`POE_B_W)
    ) u_sync_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .pin_i   (group_b_pin_i),
        .level   (b_level)
    );

    // ------------------------------------------------------------
    // pin group latches and drivers
    // ------------------------------------------------------------

    // group a holds six bits, the two above stay zero
    poe_port_slice #(
        .W         (`POE_A_W)
    ) u_group_a (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .data_we   (a_data_we),
        .oe_we     (a_oe_we),
        .wr_byte   (wbyte_q),
        .pin_level (a_level),
        .data_rd   (a_data_rd),
        .oe_rd     (a_oe_rd),
        .pin_o     (group_a_pin_o),
        .pin_oe    (group_a_pin_oe)
    );

    // group b holds all eight bits
    poe_port_slice #(
        .W         (`POE_B_W)
    ) u_group_b (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .data_we   (b_data_we),
        .oe_we     (b_oe_we),
        .wr_byte   (wbyte_q),
        .pin_level (b_level),
        .data_rd   (b_data_rd),
        .oe_rd     (b_oe_rd),
        .pin_o     (group_b_pin_o),
        .pin_oe    (group_b_pin_oe)
    );

endmodule

// ===== testbench/poe_pin_model.sv
// ------------------------------------------------------------
// outside world of one pin group
// ------------------------------------------------------------
module poe_pin_model #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic [W-1:0] pin_o,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] ext_val,
    input  wire logic         ext_en,
    output logic      [W-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [W-1:0] float_q = '0;

    // no pull on these pins: an undriven wire wanders
    always_ff @(posedge aclk) float_q <= ~float_q;

    // device driver wins, else outside source, else floating
    assign pin_i = (pin_oe & pin_o) |
                   (~pin_oe & (ext_en ? ext_val : float_q));
endmodule

// ===== testbench/poe_top_assertions.sv
`include "poe_defs.svh"

// ------------------------------------------------------------
// port relations of the output-enable block
// ------------------------------------------------------------
module poe_top_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [15:0] awaddr,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [15:0] araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [5:0]  group_a_pin_o,
    input wire logic [5:0]  group_a_pin_oe,
    input wire logic [7:0]  group_b_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [13:0] aw_q;
    logic [13:0] ar_q;
    logic [7:0]  w_q;
    logic        s_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // last accepted addresses and write byte
    always_ff @(posedge aclk) begin
        if (awvalid && awready) aw_q <= awaddr[15:2];
        if (wvalid && wready) w_q <= wdata[7:0];
        if (wvalid && wready) s_q <= wstrb[0];
        if (arvalid && arready) ar_q <= araddr[15:2];
    end

    rst_clear_a: assert property (
        $rose(aresetn) |-> {group_b_pin_oe, group_a_pin_oe} == 14'h0)
        else $error("enables not clear after reset");
    a_oe_wr_a: assert property (
        $rose(bvalid) && s_q && aw_q == `POE_IDX_A_OE
        |-> group_a_pin_oe == w_q[5:0] && bresp == `POE_RESP_OKAY)
        else $error("group a enable differs from written value");
    b_oe_wr_a: assert property (
        $rose(bvalid) && s_q && aw_q == `POE_IDX_B_OE
        |-> group_b_pin_oe == w_q)
        else $error("group b enable differs from written value");
    a_drive_lvl_a: assert property (
        $rose(bvalid) && s_q && aw_q == `POE_IDX_A_DATA
        |-> group_a_pin_o == w_q[5:0])
        else $error("group a drive level differs from latch");
    oe_hold_a: assert property (
        $changed(group_a_pin_oe) || $changed(group_b_pin_oe)
        |-> $rose(bvalid))
        else $error("enable changed without a write");
    rsvd_zero_a: assert property (
        rvalid && ar_q == `POE_IDX_A_OE |-> rdata[31:6] == 26'h0)
        else $error("reserved enable bits read nonzero");
    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    rd_lat_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");

    cover property ($rose(bvalid) && aw_q == `POE_IDX_A_OE);
    cover property (rvalid && ar_q == `POE_IDX_B_OE);
    cover property ($rose(aresetn) && $past(group_b_pin_oe, 2) != 8'h0);
endmodule

// ===== testbench/poe_top_tb.sv
bind poe_top poe_top_assertions u_poe_top_assertions (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .group_a_pin_o,
    .group_a_pin_oe, .group_b_pin_oe
);

// ------------------------------------------------------------
// self-checking bench of the output-enable block
// ------------------------------------------------------------
module poe_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] a_dat = 16'h0000;
    localparam logic [15:0] b_dat = 16'h0004;
    localparam logic [15:0] a_oe  = 16'hc2c0;
    localparam logic [15:0] b_oe  = 16'hc2c4;
    localparam logic [15:0] no_rg = 16'h0010;

    logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, ext_en = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    logic [5:0]  group_a_pin_i, group_a_pin_o, group_a_pin_oe, ext_a = 6'h0;
    logic [7:0]  group_b_pin_i, group_b_pin_o, group_b_pin_oe, ext_b = 8'h0;
    logic [31:0] rng = 32'h17;
    int          num_errors = 0, cmp_count = 0, cyc = 0;

    always #2.5 aclk = ~aclk;

    poe_top u_poe_top (
        .aclk, .aresetn, .clk_en, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .group_a_pin_i, .group_a_pin_o, .group_a_pin_oe,
        .group_b_pin_i, .group_b_pin_o, .group_b_pin_oe
    );
    poe_pin_model #(.W(6)) u_pin_a (
        .aclk, .pin_o(group_a_pin_o), .pin_oe(group_a_pin_oe),
        .ext_val(ext_a), .ext_en, .pin_i(group_a_pin_i)
    );
    poe_pin_model #(.W(8)) u_pin_b (
        .aclk, .pin_o(group_b_pin_o), .pin_oe(group_b_pin_oe),
        .ext_val(ext_b), .ext_en, .pin_i(group_b_pin_i)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // readback of an enable register, reserved bits zero
    function automatic logic [31:0] oe_exp(logic [15:0] a, logic [31:0] v);
        return {24'h0, v[7:0] & ((a == a_oe) ? 8'h3f : 8'hff)};
    endfunction

    task automatic print_verdict();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic wr(logic [15:0] a, logic [31:0] v, logic [3:0] s,
                      output logic [1:0] r);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        bready <= 1'b1;
        while (b) begin
            @(posedge aclk);
            if (aw && awready) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                b = 1'b0;
            end
        end
    endtask

    task automatic rd(logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic p;
        p = 1'b1;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        while (p) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                p = 1'b0;
            end
        end
    endtask

    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v, d, e;
        logic [1:0]  r;
        logic [15:0] oe_regs [2];
        oe_regs = '{a_oe, b_oe};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // enables clear out of reset
        chk("pin_oe", 32'h0, {group_b_pin_oe, group_a_pin_oe});
        foreach (oe_regs[i]) begin
            rd(oe_regs[i], d, r);
            chk("oe_rst", 32'h0, d);
        end
        // random enables, all ones first for the reserved bits
        for (int k = 0; k < 16; k++) begin
            v = (k == 0) ? 32'hffff_ffff : rnd();
            foreach (oe_regs[i]) begin
                wr(oe_regs[i], v, 4'hf, r);
                rd(oe_regs[i], d, r);
                e = oe_exp(oe_regs[i], v);
                chk("oe_rd", e, d);
            end
            chk("a_pin_oe", v & 32'h3f, group_a_pin_oe);
            chk("b_pin_oe", v & 32'hff, group_b_pin_oe);
        end
        // low strobe changes nothing, unmapped answers error
        wr(a_oe, 32'h0, 4'he, r);
        chk("bresp", 32'h0, r);
        chk("a_pin_oe", v & 32'h3f, group_a_pin_oe);
        wr(no_rg, 32'hff, 4'hf, r);
        chk("bresp", 32'h2, r);
        rd(no_rg, d, r);
        chk("rresp", 32'h2, r);
        chk("rdata", 32'h0, d);
        // enabled pins carry the latched level
        wr(a_oe, 32'h3f, 4'hf, r);
        wr(b_oe, 32'hff, 4'hf, r);
        v = rnd();
        wr(a_dat, v, 4'hf, r);
        wr(b_dat, v >> 8, 4'hf, r);
        chk("a_pin_o", v & 32'h3f, group_a_pin_o);
        chk("b_pin_o", (v >> 8) & 32'hff, group_b_pin_o);
        rd(a_dat, d, r);
        chk("a_dat", v & 32'h3f, d);
        // released pins follow the outside source, read back on group b only
        wr(a_oe, 32'h0, 4'hf, r);
        wr(b_oe, 32'h0, 4'hf, r);
        ext_a <= v[21:16];
        ext_b <= v[31:24];
        ext_en <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("pin_oe", 32'h0, {group_b_pin_oe, group_a_pin_oe});
        rd(b_dat, d, r);
        chk("b_dat", {24'h0, v[31:24]}, d);
        // reset in mid-run drops every enable
        wr(b_oe, 32'h5a, 4'hf, r);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("pin_oe", 32'h0, {group_b_pin_oe, group_a_pin_oe});
        rd(b_oe, d, r);
        chk("b_oe_rst", 32'h0, d);
        // low clock enable refuses every request
        clk_en <= 1'b0;
        @(posedge aclk);
        chk("ready", 32'h0, {awready, wready, arready});
        clk_en <= 1'b1;
        @(posedge aclk);
        print_verdict();
    end
endmodule
